// ==== core/fm_cfg.svh ====
// Constants for the frequency meter: offsets, field positions, resets, timing.
// Assumes a 200 MHz register clock; included by the meter and the bench.
`ifndef FM_CFG_SVH
`define FM_CFG_SVH
// ************************************************************
// Timing
// ************************************************************
`define FM_CLK_NS 5
`define FM_US_NS 1000
`define FM_US_CYC (`FM_US_NS / `FM_CLK_NS)
`define FM_SMP_STEP_MS 10
`define FM_SMP_STEP_US (`FM_SMP_STEP_MS * 1000)
`define FM_MAX_INT_S 1
`define FM_MAX_INT_US (`FM_MAX_INT_S * 1000000)
// ************************************************************
// Limits and scales
// ************************************************************
`define FM_SMP_MIN 5'h01
`define FM_SMP_MAX 5'h14
`define FM_SMP_DEF 5'h01
`define FM_PAT_CONT_MAX 10'h100
`define FM_PAT_MAX 10'h200
`define FM_SCL_MAX 11'h400
`define FM_RES_COARSE 14'h03E8
`define FM_RES_FINE 14'h2710
`define FM_FREQ_SCALE 80'h3B9ACA00
`define FM_DIV_LAST 7'h4F
// ************************************************************
// Register map
// ************************************************************
`define FM_OFF_CTRL 8'h00
`define FM_OFF_SMP 8'h04
`define FM_OFF_PAT 8'h08
`define FM_OFF_SCL 8'h0C
`define FM_OFF_STAT 8'h10
`define FM_OFF_FREQ 8'h14
`define FM_CTRL_CORR 0
`define FM_CTRL_LEARN 1
`define FM_CTRL_FINE 2
`define FM_STAT_VALID 0
`define FM_STAT_DONE 1
`define FM_STAT_LEARN 2
`define FM_STAT_CORR 3
`endif

// ==== core/fm_pkg.sv ====
// Types shared by the frequency meter.
// Assumes fm_cfg.svh is on the include path.
package fm_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SDIV, ST_NDIV} fm_fsm_t;

    typedef struct packed {
        logic corr_en;
        logic learn_req;
        logic res_fine;
        logic [4:0] smp;
        logic [9:0] pat;
        logic [10:0] scl;
    } fm_ctl_t;

    typedef struct packed {
        fm_ctl_t ctl;
        logic [1:0] sync;
        logic lvl;
        logic [10:0] pre;
        logic [7:0] usd;
        logic [31:0] now;
        logic [17:0] smp_us;
        logic [31:0] start_ts;
        logic [31:0] last_ts;
        logic have_start;
        logic [31:0] n;
        logic [47:0] csum;
        logic [8:0] ptr;
        logic learning;
        logic armed;
        logic req_d;
        logic learn_done;
        logic norm_pend;
        logic [9:0] lcnt;
        logic [31:0] ltot;
        fm_fsm_t st;
        logic [79:0] dq;
        logic [47:0] drem;
        logic [47:0] dden;
        logic [6:0] dcnt;
        logic [8:0] nidx;
        logic [31:0] freq;
        logic valid;
        logic stb;
        logic [31:0] prdata;
        logic pslverr;
    } fm_state_t;
endpackage

// ==== core/freq_meter.sv ====
// Frequency meter with pattern learning and correction, APB register slave.
// Assumes a debounced pulse input from outside the clock domain.
//
// How it works
// - Sampling period settable 10..200 ms in 10 ms steps; one result each.
// - Sampling period defaults to 10 ms after reset.
// - A result is computed only over at least one whole pulse.
// - Integration ends at the last pulse edge seen before the sample tick.
// - Integration capped at one second; below 1 Hz the result is zero.
// - Result is pulses times scale over period, in pulses per 1000 s.
// - With correction, pulses are weighted by learned per-pulse ratios.
// - Correction resolution 1:1000 by default, or 1:10000.
// - Pattern of 2..256 pulses: learning repeats while request held.
// - Pattern of 257..512 pulses: one pass per request rising edge.
// - Correction off or pattern of 1: plain result, marked valid.
// - Correction on, not yet learned: plain result, marked invalid.
// - Correction on and learned: corrected result, marked valid.
// - Learn-done flag set when learning finishes.
// - Pass ends after configured pulse count; ratios kept until power off.
// - Continuous mode keeps correction; triggered mode suspends it per pass.
// - Learning state readable in the status word.
// - Input divided by a scale factor 2..1024; factor 1 bypasses.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "fm_cfg.svh"

module freq_meter import fm_pkg::*; #(
    parameter int US_CYC = `FM_US_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pulse_in,
    output logic [31:0] freq_value,
    output logic result_stb,
    output logic value_valid,
    output logic learn_done
);
    // ************************************************************
    // State and storage
    // ************************************************************
    localparam fm_ctl_t CTL_RST = '{corr_en: 1'b0, learn_req: 1'b0, res_fine: 1'b0,
        smp: `FM_SMP_DEF, pat: 10'h001, scl: 11'h001};
    localparam fm_state_t S_RST = '{ctl: CTL_RST, st: ST_IDLE, default: '0};

    // Ratios have no reset: they must survive until power is removed
    logic [19:0] raw_mem [0:511];
    logic [19:0] ratio_mem [0:511];
    fm_state_t s;
    fm_state_t n;
    logic raw_we;
    logic rat_we;
    logic [19:0] raw_d;
    logic [19:0] rat_d;
    logic [31:0] ivl;
    logic [31:0] tper;
    logic trig;
    logic multi;
    logic [13:0] res;
    logic corr_avail;
    logic corr_act;
    logic val_now;
    logic us_tick;
    logic [17:0] per;
    logic smp_tick;
    logic near_tick;
    logic edge_in;
    logic ev;
    logic pat_last;
    logic [48:0] shf;
    logic [48:0] sub;
    logic [79:0] dq_nx;

    assign trig = s.ctl.pat > `FM_PAT_CONT_MAX;
    assign multi = s.ctl.pat > 10'h001;
    assign res = s.ctl.res_fine ? `FM_RES_FINE : `FM_RES_COARSE;
    // Triggered passes overwrite ratios in place, so correction waits
    assign corr_avail = s.learn_done & ~(trig & (s.learning | s.norm_pend));
    assign corr_act = s.ctl.corr_en & multi & corr_avail;
    assign val_now = ~(s.ctl.corr_en & multi) | corr_avail;
    assign us_tick = s.usd == 8'(US_CYC - 1);
    assign per = 18'(s.ctl.smp * `FM_SMP_STEP_US);
    assign smp_tick = us_tick & (s.smp_us >= per - 18'h00001);
    // A ratio entry takes 80 cycles; never start one in the last two microseconds
    assign near_tick = s.smp_us >= per - 18'h00002;
    assign edge_in = s.sync[1] & ~s.lvl;
    assign ev = edge_in & (s.pre >= s.ctl.scl - 11'h001);
    assign pat_last = s.ptr >= 9'(s.ctl.pat - 10'h001);
    assign ivl = s.now - s.last_ts;
    assign raw_d = (|ivl[31:20]) ? 20'hFFFFF : ivl[19:0];
    assign shf = {s.drem, s.dq[79]};
    assign sub = shf - {1'b0, s.dden};
    assign dq_nx = {s.dq[78:0], ~sub[48]};

    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = s.pslverr;
    assign freq_value = s.freq;
    assign result_stb = s.stb;
    assign value_valid = s.valid;
    assign learn_done = s.learn_done;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n = s;
        raw_we = 1'b0;
        rat_we = 1'b0;
        rat_d = (|dq_nx[79:20]) ? 20'hFFFFF : dq_nx[19:0];
        tper = 32'h00000001;
        n.stb = 1'b0;
        n.req_d = s.ctl.learn_req;
        n.sync = {s.sync[0], pulse_in};
        n.lvl = s.sync[1];
        n.usd = us_tick ? 8'h00 : s.usd + 8'h01;
        if (us_tick) begin
            n.now = s.now + 32'h00000001;
            n.smp_us = smp_tick ? 18'h00000 : s.smp_us + 18'h00001;
        end

        if (edge_in) begin
            n.pre = (s.pre >= s.ctl.scl - 11'h001) ? 11'h000 : s.pre + 11'h001;
        end

        if (ev) begin
            n.last_ts = s.now;
            if (s.have_start) begin
                n.n = s.n + 32'h00000001;
                n.csum = corr_avail ? s.csum + 48'(ratio_mem[s.ptr]) : s.csum;
            end else begin
                n.start_ts = s.now;
                n.have_start = 1'b1;
            end
            if (s.learning & ~s.armed) begin
                raw_we = 1'b1;
                n.ltot = s.ltot + 32'(raw_d);
                n.lcnt = s.lcnt + 10'h001;
                if (n.lcnt == s.ctl.pat) begin
                    n.learning = 1'b0;
                    n.norm_pend = 1'b1;
                    n.nidx = 9'h000;
                end
            end
            // Relearning waits for a pattern wrap so old ratios stay aligned
            if (s.armed & (~s.learn_done | pat_last)) begin
                n.armed = 1'b0;
                n.ptr = 9'h000;
            end else begin
                n.ptr = pat_last ? 9'h000 : s.ptr + 9'h001;
            end
        end

        // Request is only sampled to start a pass; dropping it later is harmless
        if (~s.learning & ~s.norm_pend & multi) begin
            if (trig ? (s.ctl.learn_req & ~s.req_d) : s.ctl.learn_req) begin
                n.learning = 1'b1;
                n.armed = 1'b1;
                n.lcnt = 10'h000;
                n.ltot = 32'h00000000;
            end
        end

        unique case (s.st)
            ST_IDLE: begin
                if (s.norm_pend & ~near_tick & ~smp_tick) begin
                    n.st = ST_NDIV;
                    n.dq = 80'(raw_mem[s.nidx]) * 80'(res) * 80'(s.ctl.pat);
                    n.dden = 48'(s.ltot);
                    n.drem = 48'h0;
                    n.dcnt = 7'h00;
                end
            end
            ST_SDIV, ST_NDIV: begin
                n.drem = sub[48] ? shf[47:0] : sub[47:0];
                n.dq = dq_nx;
                n.dcnt = s.dcnt + 7'h01;
                if (s.dcnt == `FM_DIV_LAST) begin
                    n.st = ST_IDLE;
                    if (s.st == ST_SDIV) begin
                        n.freq = (|dq_nx[79:32]) ? 32'hFFFFFFFF : dq_nx[31:0];
                        n.stb = 1'b1;
                        n.valid = val_now;
                    end else begin
                        rat_we = 1'b1;
                        n.nidx = s.nidx + 9'h001;
                        if (s.nidx >= 9'(s.ctl.pat - 10'h001)) begin
                            n.norm_pend = 1'b0;
                            n.learn_done = 1'b1;
                        end
                    end
                end
            end
        endcase

        if (smp_tick) begin
            if (n.n != 32'h00000000) begin
                tper = n.last_ts - n.start_ts;
                if (tper == 32'h00000000) begin
                    tper = 32'h00000001;
                end
                n.st = ST_SDIV;
                n.drem = 48'h0;
                n.dcnt = 7'h00;
                if (corr_act) begin
                    n.dq = 80'(n.csum) * `FM_FREQ_SCALE;
                    n.dden = 48'(tper) * 48'(res);
                end else begin
                    n.dq = 80'(n.n) * `FM_FREQ_SCALE;
                    n.dden = 48'(tper);
                end
                n.start_ts = n.last_ts;
                n.n = 32'h00000000;
                n.csum = 48'h0;
            end else begin
                n.stb = 1'b1;
                n.valid = val_now;
                if (~n.have_start | (n.now - n.start_ts >= 32'(`FM_MAX_INT_US))) begin
                    n.freq = 32'h00000000;
                    n.have_start = 1'b0;
                end
            end
        end

        if (psel & ~penable) begin
            n.pslverr = 1'b0;
            n.prdata = 32'h00000000;
            unique case (paddr)
                `FM_OFF_CTRL: begin
                    n.prdata[`FM_CTRL_CORR] = s.ctl.corr_en;
                    n.prdata[`FM_CTRL_LEARN] = s.ctl.learn_req;
                    n.prdata[`FM_CTRL_FINE] = s.ctl.res_fine;
                end
                `FM_OFF_SMP: n.prdata = 32'(s.ctl.smp);
                `FM_OFF_PAT: n.prdata = 32'(s.ctl.pat);
                `FM_OFF_SCL: n.prdata = 32'(s.ctl.scl);
                `FM_OFF_STAT: begin
                    n.prdata[`FM_STAT_VALID] = s.valid;
                    n.prdata[`FM_STAT_DONE] = s.learn_done;
                    n.prdata[`FM_STAT_LEARN] = s.learning | s.norm_pend;
                    n.prdata[`FM_STAT_CORR] = corr_act;
                end
                `FM_OFF_FREQ: n.prdata = s.freq;
                default: n.pslverr = 1'b1;
            endcase
        end

        if (psel & penable & pwrite) begin
            unique case (paddr)
                `FM_OFF_CTRL: begin
                    n.ctl.corr_en = pwdata[`FM_CTRL_CORR];
                    n.ctl.learn_req = pwdata[`FM_CTRL_LEARN];
                    n.ctl.res_fine = pwdata[`FM_CTRL_FINE];
                end
                `FM_OFF_SMP: begin
                    if (pwdata[4:0] == 5'h00) begin
                        n.ctl.smp = `FM_SMP_MIN;
                    end else if (pwdata > 32'(`FM_SMP_MAX)) begin
                        n.ctl.smp = `FM_SMP_MAX;
                    end else begin
                        n.ctl.smp = pwdata[4:0];
                    end
                end
                `FM_OFF_PAT: begin
                    if (pwdata[9:0] == 10'h000) begin
                        n.ctl.pat = 10'h001;
                    end else if (pwdata > 32'(`FM_PAT_MAX)) begin
                        n.ctl.pat = `FM_PAT_MAX;
                    end else begin
                        n.ctl.pat = pwdata[9:0];
                    end
                end
                `FM_OFF_SCL: begin
                    if (pwdata[10:0] == 11'h000) begin
                        n.ctl.scl = 11'h001;
                    end else if (pwdata > 32'(`FM_SCL_MAX)) begin
                        n.ctl.scl = `FM_SCL_MAX;
                    end else begin
                        n.ctl.scl = pwdata[10:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= S_RST;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge pclk) begin
        if (raw_we) begin
            raw_mem[s.ptr] <= raw_d;
        end
        if (rat_we) begin
            ratio_mem[s.nidx] <= rat_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    smp_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.ctl.smp >= `FM_SMP_MIN && s.ctl.smp <= `FM_SMP_MAX)
        else $error("sampling factor out of range");
    smp_default_a: assert property (@(posedge pclk) $rose(presetn) |->
        s.ctl.smp == `FM_SMP_DEF && per == 18'(`FM_SMP_STEP_US))
        else $error("sampling period not 10 ms after reset");
    one_result_a: assert property (@(posedge pclk) disable iff (!presetn)
        smp_tick |-> ##[1:90] s.stb)
        else $error("no result for a sampling period");
    whole_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s.st == ST_SDIV) |-> s.dq != 80'h0 && s.dden != 48'h0)
        else $error("result computed without a pulse");
    cap_1s_a: assert property (@(posedge pclk) disable iff (!presetn)
        smp_tick && n.n == 32'h0 && s.have_start
        && (s.now - s.start_ts >= 32'(`FM_MAX_INT_US)) |=> s.stb && s.freq == 32'h0)
        else $error("overlong integration not zeroed");
    valid_plain_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.stb && !$past(s.ctl.corr_en && multi) |-> s.valid)
        else $error("plain result not valid");
    valid_learn_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.stb && $past(s.ctl.corr_en && multi && !s.learn_done) |-> !s.valid)
        else $error("unlearned result marked valid");
    valid_corr_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.stb && $past(corr_act) |-> s.valid)
        else $error("corrected result not valid");
    trig_suspend_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig && (s.learning || s.norm_pend) |-> !corr_act)
        else $error("correction used during triggered pass");
    cont_repeat_a: assert property (@(posedge pclk) disable iff (!presetn)
        !trig && multi && s.ctl.learn_req && !s.learning && !s.norm_pend |=> s.learning)
        else $error("continuous learning did not restart");
    trig_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig && s.ctl.learn_req && s.req_d && !s.learning && !s.norm_pend |=> !s.learning)
        else $error("triggered learning without rising edge");
    done_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.learn_done |=> s.learn_done)
        else $error("learned pattern lost");
    prescale_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev |=> s.pre == 11'h000 ##0 $past(s.pre) >= $past(s.ctl.scl) - 11'h001)
        else $error("scaled pulse at wrong count");

    plain_cov: cover property (@(posedge pclk) disable iff (!presetn)
        s.stb && s.valid && s.freq != 32'h0);
    learned_cov: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(s.learn_done));
    corrected_cov: cover property (@(posedge pclk) disable iff (!presetn)
        smp_tick && corr_act && n.n != 32'h0);
    timeout_cov: cover property (@(posedge pclk) disable iff (!presetn)
        s.stb && s.freq == 32'h0 && $past(s.have_start));
endmodule

// ==== tb/pickup_model.sv ====
// Pickup sensor model: a debounced pulse train with two alternating gaps.
// Assumes gaps in pclk cycles, each above 20 so every pulse has a low phase.
`timescale 1ns/1ps

module pickup_model (
    input wire logic pclk,
    input wire logic run,
    input wire logic [31:0] gap_a,
    input wire logic [31:0] gap_b,
    output logic pulse_in
);
    logic [31:0] cnt;
    logic sel;

    initial begin
        cnt = 32'h0;
        sel = 1'b0;
        pulse_in = 1'b0;
    end

    // Gaps only change between tests, so speed is steady within a pass
    // Two gaps model an irregular tooth pattern of period two
    always @(posedge pclk) begin
        if (!run) begin
            cnt <= 32'h0;
            pulse_in <= 1'b0;
        end else if (cnt == 32'h0) begin
            pulse_in <= 1'b1;
            cnt <= (sel ? gap_b : gap_a) - 32'h1;
            sel <= ~sel;
        end else begin
            cnt <= cnt - 32'h1;
            // Short low phase, well above the one-cycle minimum
            if (cnt == 32'h14) begin
                pulse_in <= 1'b0;
            end
        end
    end
endmodule

// ==== tb/frequency_meter_pattern_correction_tb.sv ====
// Self-checking bench for the frequency meter with pattern correction.
// Assumes fm_pkg, fm_cfg.svh and pickup_model; the timebase ticks every cycle.
`timescale 1ns/1ps
`include "fm_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module frequency_meter_pattern_correction_tb import fm_pkg::*;;
    typedef struct packed {
        logic [1:0] mode;
        logic [31:0] f;
        logic v;
    } note_t;

    localparam logic [31:0] F_10K = 32'h00989680;
    localparam logic [31:0] F_2K5 = 32'h002625A0;
    localparam logic [31:0] F_20K = 32'h01312D00;
    localparam int LIMIT = 32'h0003D090;

    logic pclk, presetn, psel, penable, pwrite, pulse_in, run, err;
    logic pready, pslverr, result_stb, value_valid, learn_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, freq_value, gap_a, gap_b, rd, seed;
    int errors, samples_checked, cyc;
    note_t notes[$];
    note_t cur;

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // One-cycle timebase tick keeps a 10 ms period at 10000 cycles
    freq_meter #(.US_CYC(1)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
        .freq_value(freq_value), .result_stb(result_stb), .value_valid(value_valid),
        .learn_done(learn_done));

    pickup_model i_pickup (.pclk(pclk), .run(run), .gap_a(gap_a), .gap_b(gap_b),
        .pulse_in(pulse_in));

    // ************************************************************
    // Result watcher: oldest note against each strobe
    // ************************************************************
    always @(posedge pclk) begin
        if (result_stb === 1'b1 && notes.size() > 0) begin
            cur = notes.pop_front();
            if (cur.mode != 2'h0) `CHK("value_valid", cur.v, value_valid);
            if (cur.mode == 2'h2) `CHK("freq_value", cur.f, freq_value);
        end
    end

    // Each sampling period is 10000 cycles; the ceiling allows about twenty-five
    always @(posedge pclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            end_of_test();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", e, rd);
    endtask

    // Mode 0 skips a strobe, 1 checks the flag, 2 checks flag and value
    task automatic expect_res(input int skip, input int n, input logic [1:0] m,
        input logic [31:0] f, input logic v);
        repeat (skip) notes.push_back('{2'h0, 32'h0, 1'b0});
        repeat (n) notes.push_back('{m, f, v});
        while (notes.size() > 0) @(posedge pclk);
    endtask

    task automatic wait_stat(input int b, input logic val);
        int k;
        for (k = 0; k < 400; k++) begin
            apb(1'b0, `FM_OFF_STAT, 32'h0);
            if (rd[b] === val) break;
            repeat (500) @(posedge pclk);
        end
        `CHK("status_bit", val, rd[b]);
    endtask

    task automatic test_done(input string nm);
        $display("Test %s done", nm);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        run = 1'b0;
        gap_a = 32'h64;
        gap_b = 32'h64;
        seed = 32'h0cab;
        errors = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`FM_OFF_CTRL, 32'h0);
        rchk(`FM_OFF_SMP, 32'h1);
        rchk(`FM_OFF_PAT, 32'h1);
        rchk(`FM_OFF_SCL, 32'h1);
        rchk(`FM_OFF_STAT, 32'h0);
        apb(1'b1, `FM_OFF_SMP, 32'h19);
        rchk(`FM_OFF_SMP, 32'h14);
        apb(1'b1, `FM_OFF_SMP, 32'h0);
        rchk(`FM_OFF_SMP, 32'h1);
        apb(1'b1, 8'h20, $random(seed));
        `CHK("pslverr", 1'b1, err);
        apb(1'b1, `FM_OFF_STAT, $random(seed));
        rchk(`FM_OFF_STAT, 32'h0);
        test_done("registers");
        apb(1'b1, `FM_OFF_CTRL, 32'h1);
        run <= 1'b1;
        expect_res(1, 2, 2'h2, F_10K, 1'b1);
        test_done("plain");
        apb(1'b1, `FM_OFF_CTRL, 32'h0);
        apb(1'b1, `FM_OFF_SCL, 32'h4);
        expect_res(1, 1, 2'h2, F_2K5, 1'b1);
        apb(1'b1, `FM_OFF_SCL, 32'h1);
        test_done("scaling");
        gap_a <= 32'h3C;
        gap_b <= 32'h8C;
        apb(1'b1, `FM_OFF_PAT, 32'h2);
        apb(1'b1, `FM_OFF_CTRL, 32'h1);
        expect_res(1, 1, 2'h1, 32'h0, 1'b0);
        apb(1'b1, `FM_OFF_CTRL, 32'h3);
        wait_stat(`FM_STAT_DONE, 1'b1);
        `CHK("learn_done", 1'b1, learn_done);
        // Request may drop once learning has begun
        apb(1'b1, `FM_OFF_CTRL, 32'h1);
        expect_res(1, 1, 2'h2, F_10K, 1'b1);
        rchk(`FM_OFF_STAT, 32'hB);
        test_done("continuous");
        // Faster teeth shorten the long triggered pass
        gap_a <= 32'h1E;
        gap_b <= 32'h46;
        apb(1'b1, `FM_OFF_PAT, 32'h102);
        apb(1'b1, `FM_OFF_CTRL, 32'h5);
        apb(1'b1, `FM_OFF_CTRL, 32'h7);
        wait_stat(`FM_STAT_LEARN, 1'b1);
        `CHK("corr_active", 1'b0, rd[`FM_STAT_CORR]);
        wait_stat(`FM_STAT_LEARN, 1'b0);
        expect_res(1, 1, 2'h2, F_20K, 1'b1);
        rchk(`FM_OFF_STAT, 32'hB);
        test_done("triggered");
        end_of_test();
    end
endmodule
